// ### hw/wtl_consts.svh
`ifndef WTL_CONSTS_SVH
`define WTL_CONSTS_SVH
// Behaviour
// - Control bit 7 shows whether the wake-up timer is counting.
// - A write changes the running bit only when it also sets control bit 6.
// - Bit 5 set launches an oscillator trimming run at every underflow.
// - Bit 4 set starts a card detection sequence when the timer fires.
// - Card found raises interrupt and stays active; none found allows power-down.
// - During card detection the timer restarts at once, with no gap.
// - Fourth general timer sets the RF field time of the detection check.
// - Bit 3 set reloads at zero and keeps counting; clear stops at zero unless bit 4 is set.
// - Every underflow sets the wake-up timer interrupt flag.
// - Bit 2 set wakes the chip from power-down at underflow.
// - Bit 2 set returns to power-down after a run without card; else active.
// - Bits 1:0 divide the oscillator clock by 1, 8, 16 or 32.
// - 16-bit reload in two byte registers, copied into the counter at start.
// - Live counter readable as high and low bytes in bits 7:0.

// ==========================================
// Register indices (byte address = 4 * index)
`define WTL_IDX_CONTROL 8'h23
`define WTL_IDX_RELOAD_HIGH 8'h24
`define WTL_IDX_RELOAD_LOW 8'h25
`define WTL_IDX_COUNT_HIGH 8'h26
`define WTL_IDX_COUNT_LOW 8'h27
`define WTL_IDX_IRQ_STATUS 8'h30
`define WTL_IDX_IRQ_MASK 8'h31

// ==========================================
// Control field positions
`define WTL_BIT_RUNNING 7
`define WTL_BIT_PERMIT 6
`define WTL_BIT_AUTO_TRIM 5
`define WTL_BIT_AUTO_CARD 4
`define WTL_BIT_AUTO_RELOAD 3
`define WTL_BIT_AUTO_WAKE 2
`define WTL_BIT_PRESC_HI 1
`define WTL_BIT_PRESC_LO 0

// ==========================================
// Interrupt status bits
`define WTL_IRQ_UNDERFLOW 0
`define WTL_IRQ_CARD 1
`define WTL_IRQ_BITS 2

// ==========================================
// Reset values and prescale counts
`define WTL_RST_CONTROL 8'h00
`define WTL_RST_RELOAD 16'h0000
`define WTL_RST_MASK 2'h0
`define WTL_RST_COUNT 16'h0000
`define WTL_RST_PRESC 5'h00
`define WTL_DIV1_LAST 5'h00
`define WTL_DIV8_LAST 5'h07
`define WTL_DIV16_LAST 5'h0f
`define WTL_DIV32_LAST 5'h1f
`endif

// ### hw/wtl_pkg.sv
package wtl_pkg;
    typedef logic [7:0] wtl_byte_t;
    typedef enum logic [1:0] {
        WTL_DIV_1,
        WTL_DIV_8,
        WTL_DIV_16,
        WTL_DIV_32
    } wtl_presc_e;
    typedef enum logic [0:0] {
        WTL_SEQ_IDLE,
        WTL_SEQ_BUSY
    } wtl_seq_e;
endpackage : wtl_pkg

// ### hw/wtl_top.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "wtl_consts.svh"
module wtl_top
    import wtl_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Avalon-MM slave
    input wire logic [9:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic [1:0] AVS_RESPONSE,
    output logic AVS_WAITREQUEST,
    // Low-frequency oscillator
    input wire logic LOW_FREQ_OSC_TICK,
    // Trimming engine
    output logic TRIM_START,
    input wire logic TRIM_DONE,
    // Card detection engine
    output logic CARD_DETECT_START,
    output logic CARD_FIELD_TIMER_SEL,
    input wire logic CARD_DETECT_DONE,
    input wire logic CARD_FOUND,
    // Power management
    output logic WAKE_REQ,
    output logic POWER_DOWN_REQ,
    // Interrupt
    output logic IRQ
);

    // Counter, reload and readback paths are built for 16 bits only
    if (COUNT_WIDTH != 16) begin : g_width_check
        $error("COUNT_WIDTH must be 16");
    end

    // ==========================================
    // Bus access
    logic ack_q;
    logic [7:0] index;
    logic wr_fire;
    logic rd_start;
    logic byte0_wr;
    logic mapped;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;

    assign index = AVS_ADDRESS[9:2];
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign wr_fire = AVS_WRITE & ack_q;
    assign rd_start = AVS_READ & ~ack_q;
    assign byte0_wr = wr_fire & AVS_BYTEENABLE[0];
    assign AVS_READDATA = rdata_q;
    assign AVS_RESPONSE = resp_q;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
        end
    end

    // ==========================================
    // Control and reload registers
    logic running_q;
    logic auto_osc_trim_enable_q;
    logic auto_card_detect_enable_q;
    logic auto_reload_enable_q;
    logic auto_wake_enable_q;
    wtl_presc_e prescale_select_q;
    logic [15:0] reload_word_q;
    logic [15:0] count_q;
    logic [`WTL_IRQ_BITS-1:0] irq_status_q;
    logic [`WTL_IRQ_BITS-1:0] irq_mask_q;
    logic ctrl_wr;
    logic run_wr;
    logic start_evt;
    logic stop_evt;
    logic tick;
    logic underflow;
    logic card_evt;

    assign ctrl_wr = byte0_wr && index == `WTL_IDX_CONTROL;
    assign run_wr = ctrl_wr && AVS_WRITEDATA[`WTL_BIT_PERMIT];
    assign start_evt = run_wr && AVS_WRITEDATA[`WTL_BIT_RUNNING];
    assign stop_evt = run_wr && !AVS_WRITEDATA[`WTL_BIT_RUNNING];

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            auto_osc_trim_enable_q <= 1'b0;
            auto_card_detect_enable_q <= 1'b0;
            auto_reload_enable_q <= 1'b0;
            auto_wake_enable_q <= 1'b0;
            prescale_select_q <= WTL_DIV_1;
        end else if (ctrl_wr) begin
            auto_osc_trim_enable_q <= AVS_WRITEDATA[`WTL_BIT_AUTO_TRIM];
            auto_card_detect_enable_q <= AVS_WRITEDATA[`WTL_BIT_AUTO_CARD];
            auto_reload_enable_q <= AVS_WRITEDATA[`WTL_BIT_AUTO_RELOAD];
            auto_wake_enable_q <= AVS_WRITEDATA[`WTL_BIT_AUTO_WAKE];
            prescale_select_q <= wtl_presc_e'(
                AVS_WRITEDATA[`WTL_BIT_PRESC_HI:`WTL_BIT_PRESC_LO]);
        end
    end

    // Reload bytes only latch; counter sees them at the next start or underflow reload
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            reload_word_q <= `WTL_RST_RELOAD;
        end else if (byte0_wr && index == `WTL_IDX_RELOAD_HIGH) begin
            reload_word_q[15:8] <= AVS_WRITEDATA[7:0];
        end else if (byte0_wr && index == `WTL_IDX_RELOAD_LOW) begin
            reload_word_q[7:0] <= AVS_WRITEDATA[7:0];
        end
    end

    // ==========================================
    // Prescaler
    logic [4:0] presc_q;
    logic [4:0] presc_last;

    always_comb begin
        unique case (prescale_select_q)
            WTL_DIV_1: presc_last = `WTL_DIV1_LAST;
            WTL_DIV_8: presc_last = `WTL_DIV8_LAST;
            WTL_DIV_16: presc_last = `WTL_DIV16_LAST;
            WTL_DIV_32: presc_last = `WTL_DIV32_LAST;
        endcase
    end

    assign tick = running_q && LOW_FREQ_OSC_TICK && presc_q >= presc_last;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            presc_q <= `WTL_RST_PRESC;
        end else if (start_evt || !running_q) begin
            presc_q <= `WTL_RST_PRESC;
        end else if (LOW_FREQ_OSC_TICK) begin
            presc_q <= (presc_q >= presc_last) ? 5'h00 : presc_q + 5'h01;
        end
    end

    // ==========================================
    // Counter and running state
    assign underflow = tick && count_q == 16'h0000;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            running_q <= 1'b0;
        end else if (run_wr) begin
            running_q <= AVS_WRITEDATA[`WTL_BIT_RUNNING];
        end else if (underflow && !auto_reload_enable_q && !auto_card_detect_enable_q) begin
            running_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            count_q <= `WTL_RST_COUNT;
        end else if (start_evt) begin
            count_q <= reload_word_q;
        end else if (underflow) begin
            if (auto_reload_enable_q || auto_card_detect_enable_q) begin
                count_q <= reload_word_q;
            end
        end else if (tick) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // ==========================================
    // Trimming and card detection sequence
    wtl_seq_e seq_q;
    logic trim_busy_q;
    logic card_busy_q;
    logic card_seen_q;
    logic trim_start_q;
    logic card_start_q;
    logic wake_q;
    logic pdown_q;

    assign TRIM_START = trim_start_q;
    assign CARD_DETECT_START = card_start_q;
    assign CARD_FIELD_TIMER_SEL = card_busy_q;
    assign WAKE_REQ = wake_q;
    assign POWER_DOWN_REQ = pdown_q;
    assign card_evt = card_busy_q && CARD_DETECT_DONE && CARD_FOUND;

    // Each start pulse lasts one cycle, the cycle after the underflow
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            trim_start_q <= 1'b0;
        end else begin
            trim_start_q <= underflow && auto_osc_trim_enable_q;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            card_start_q <= 1'b0;
        end else begin
            card_start_q <= underflow && auto_card_detect_enable_q;
        end
    end

    // Wake request to power management, one cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= underflow && auto_wake_enable_q;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            trim_busy_q <= 1'b0;
        end else if (trim_start_q) begin
            trim_busy_q <= 1'b1;
        end else if (TRIM_DONE) begin
            trim_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            card_busy_q <= 1'b0;
        end else if (card_start_q) begin
            card_busy_q <= 1'b1;
        end else if (CARD_DETECT_DONE) begin
            card_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            seq_q <= WTL_SEQ_IDLE;
            card_seen_q <= 1'b0;
            pdown_q <= 1'b0;
        end else begin
            pdown_q <= 1'b0;
            unique case (seq_q)
                WTL_SEQ_IDLE: begin
                    if (trim_start_q || card_start_q) begin
                        seq_q <= WTL_SEQ_BUSY;
                        card_seen_q <= 1'b0;
                    end
                end
                WTL_SEQ_BUSY: begin
                    if (card_evt) begin
                        card_seen_q <= 1'b1;
                    end
                    if (!trim_busy_q && !card_busy_q && !trim_start_q && !card_start_q) begin
                        seq_q <= WTL_SEQ_IDLE;
                        pdown_q <= auto_wake_enable_q && !card_seen_q;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Interrupt status and mask
    logic [`WTL_IRQ_BITS-1:0] irq_set;
    logic [`WTL_IRQ_BITS-1:0] irq_clr;

    assign irq_set = {card_evt, underflow};
    assign irq_clr = (byte0_wr && index == `WTL_IDX_IRQ_STATUS) ?
        AVS_WRITEDATA[`WTL_IRQ_BITS-1:0] : '0;
    assign IRQ = |(irq_status_q & irq_mask_q);

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            irq_mask_q <= `WTL_RST_MASK;
        end else if (byte0_wr && index == `WTL_IDX_IRQ_MASK) begin
            irq_mask_q <= AVS_WRITEDATA[`WTL_IRQ_BITS-1:0];
        end
    end

    // ==========================================
    // Read data
    always_comb begin
        rdata_d = 32'h0000_0000;
        mapped = 1'b1;
        unique case (index)
            `WTL_IDX_CONTROL: rdata_d[7:0] = {running_q, 1'b0, auto_osc_trim_enable_q,
                auto_card_detect_enable_q, auto_reload_enable_q, auto_wake_enable_q,
                prescale_select_q};
            `WTL_IDX_RELOAD_HIGH: rdata_d[7:0] = reload_word_q[15:8];
            `WTL_IDX_RELOAD_LOW: rdata_d[7:0] = reload_word_q[7:0];
            `WTL_IDX_COUNT_HIGH: rdata_d[7:0] = count_q[15:8];
            `WTL_IDX_COUNT_LOW: rdata_d[7:0] = count_q[7:0];
            `WTL_IDX_IRQ_STATUS: rdata_d[`WTL_IRQ_BITS-1:0] = irq_status_q;
            `WTL_IDX_IRQ_MASK: rdata_d[`WTL_IRQ_BITS-1:0] = irq_mask_q;
            default: mapped = 1'b0;
        endcase
    end

    // Data captured on the first request cycle, shown while waitrequest is low
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_start) begin
            rdata_q <= rdata_d;
        end
    end

    // Unmapped index answers with a slave error, read or write
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            resp_q <= 2'h0;
        end else if (AVS_WAITREQUEST) begin
            resp_q <= mapped ? 2'h0 : 2'h2;
        end
    end

endmodule : wtl_top

// ### dv/wtl_top_checker.sv
`timescale 1ns/1ps
module wtl_top_checker #(
    parameter int COUNT_WIDTH = 16
) (
    // Clock, reset and bus
    input wire logic CLOCK, input wire logic RST_B, input wire logic [9:0] AVS_ADDRESS,
    input wire logic AVS_READ, input wire logic AVS_WRITE, input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE, input wire logic [31:0] AVS_READDATA,
    input wire logic [1:0] AVS_RESPONSE, input wire logic AVS_WAITREQUEST,
    // Timer side
    input wire logic LOW_FREQ_OSC_TICK, input wire logic TRIM_START,
    input wire logic TRIM_DONE, input wire logic CARD_DETECT_START,
    input wire logic CARD_FIELD_TIMER_SEL, input wire logic CARD_DETECT_DONE,
    input wire logic CARD_FOUND, input wire logic WAKE_REQ,
    input wire logic POWER_DOWN_REQ, input wire logic IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // ==========================================
    // Bus handshake
    sequence s_one_wait;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    property p_bus_wait;
        $rose(AVS_READ) || $rose(AVS_WRITE) |-> s_one_wait;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("wait state count wrong");
    property p_bus_idle;
        !AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("waitrequest while idle");
    property p_resp;
        (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST |-> AVS_RESPONSE ==
            ((AVS_ADDRESS[9:2] inside {[8'h23:8'h27], 8'h30, 8'h31}) ? 2'h0 : 2'h2);
    endproperty
    a_resp: assert property (p_resp) else $error("response code wrong");
    property p_rd_zero;
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");
    // ==========================================
    // Timer events
    property p_trim_pulse;
        TRIM_START |=> !TRIM_START;
    endproperty
    a_trim_pulse: assert property (p_trim_pulse) else $error("trim start too long");
    property p_card_start;
        CARD_DETECT_START |=> CARD_FIELD_TIMER_SEL && !CARD_DETECT_START;
    endproperty
    a_card_start: assert property (p_card_start) else $error("card start wrong");
    property p_wake_pulse;
        WAKE_REQ |=> !WAKE_REQ;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
    property p_pd_cause;
        POWER_DOWN_REQ |-> $past(TRIM_DONE, 2) || $past(CARD_DETECT_DONE, 2);
    endproperty
    a_pd_cause: assert property (p_pd_cause) else $error("power-down without run end");
    property p_pd_found;
        CARD_DETECT_DONE && CARD_FOUND && CARD_FIELD_TIMER_SEL |-> ##2 !POWER_DOWN_REQ;
    endproperty
    a_pd_found: assert property (p_pd_found) else $error("power-down with card");
    property p_field_end;
        $fell(CARD_FIELD_TIMER_SEL) |-> $past(CARD_DETECT_DONE);
    endproperty
    a_field_end: assert property (p_field_end) else $error("field timer released early");
endmodule : wtl_top_checker

// ### dv/test_wtl_top.sv
`timescale 1ns/1ps
module test_wtl_top;
    logic CLOCK, RST_B, AVS_READ, AVS_WRITE, LOW_FREQ_OSC_TICK, TRIM_DONE;
    logic CARD_DETECT_DONE, CARD_FOUND, AVS_WAITREQUEST, TRIM_START, CARD_DETECT_START;
    logic CARD_FIELD_TIMER_SEL, WAKE_REQ, POWER_DOWN_REQ, IRQ;
    logic [9:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [1:0] AVS_RESPONSE;
    int errors, num_checks, n_trim, n_card, n_wake, n_pd;
    wtl_top #(.COUNT_WIDTH(16)) wtl_top_inst (.CLOCK(CLOCK), .RST_B(RST_B),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(AVS_READDATA),
        .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .LOW_FREQ_OSC_TICK(LOW_FREQ_OSC_TICK), .TRIM_START(TRIM_START), .TRIM_DONE(TRIM_DONE),
        .CARD_DETECT_START(CARD_DETECT_START), .CARD_FIELD_TIMER_SEL(CARD_FIELD_TIMER_SEL),
        .CARD_DETECT_DONE(CARD_DETECT_DONE), .CARD_FOUND(CARD_FOUND), .WAKE_REQ(WAKE_REQ),
        .POWER_DOWN_REQ(POWER_DOWN_REQ), .IRQ(IRQ));
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // ==========================================
    // Event pulse counters
    always @(posedge CLOCK) begin
        n_trim <= n_trim + TRIM_START;
        n_card <= n_card + CARD_DETECT_START;
        n_wake <= n_wake + WAKE_REQ;
        n_pd <= n_pd + POWER_DOWN_REQ;
    end
    // ==========================================
    // Shared tasks
    task results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : check
    task bus(input logic rd, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        int i;
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_WRITEDATA <= {24'h0, d};
        AVS_READ <= rd;
        AVS_WRITE <= !rd;
        i = 0;
        do begin
            @(posedge CLOCK);
            i++;
        end while (AVS_WAITREQUEST !== 1'b0 && i < 50);
        if (AVS_WAITREQUEST !== 1'b0) begin
            errors++;
            results();
        end
        // Read data taken at the edge that sees waitrequest low
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLOCK);
    endtask : bus
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, idx, d, q);
    endtask : wr
    task rdc(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b1, idx, 8'h00, q);
        check($sformatf("reg %h", idx), {24'h0, e}, q);
    endtask : rdc
    task tick(input int n);
        repeat (n) begin
            LOW_FREQ_OSC_TICK <= 1'b1;
            @(posedge CLOCK);
            LOW_FREQ_OSC_TICK <= 1'b0;
            @(posedge CLOCK);
        end
    endtask : tick
    task card_done(input logic f);
        CARD_FOUND <= f;
        CARD_DETECT_DONE <= 1'b1;
        @(posedge CLOCK);
        CARD_DETECT_DONE <= 1'b0;
        repeat (3) @(posedge CLOCK);
    endtask : card_done
    // ==========================================
    // Scenarios
    task t_regs;
        rdc(8'h23, 8'h00);
        wr(8'h24, 8'h01);
        wr(8'h25, 8'h02);
        rdc(8'h24, 8'h01);
        rdc(8'h25, 8'h02);
        wr(8'h40, 8'hff);
        rdc(8'h40, 8'h00);
    endtask : t_regs
    task t_run;
        wr(8'h23, 8'h80);
        rdc(8'h23, 8'h00);
        wr(8'h23, 8'hc0);
        rdc(8'h23, 8'h80);
        rdc(8'h26, 8'h01);
        tick(1);
        rdc(8'h27, 8'h01);
        wr(8'h25, 8'h55);
        rdc(8'h27, 8'h01);
        wr(8'h23, 8'h40);
        tick(2);
        rdc(8'h27, 8'h01);
        wr(8'h26, 8'hff);
        rdc(8'h26, 8'h01);
    endtask : t_run
    task t_underflow;
        wr(8'h24, 8'h00);
        wr(8'h25, 8'h02);
        wr(8'h23, 8'hc4);
        tick(2);
        rdc(8'h30, 8'h00);
        tick(1);
        rdc(8'h30, 8'h01);
        rdc(8'h23, 8'h04);
        check("wake", 1, n_wake);
        check("irq", 0, IRQ);
        wr(8'h31, 8'h01);
        check("irq", 1, IRQ);
        wr(8'h30, 8'h01);
        check("irq", 0, IRQ);
        rdc(8'h30, 8'h00);
    endtask : t_underflow
    task t_prescale;
        int dv [4] = '{1, 8, 16, 32};
        wr(8'h25, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h23, 8'hc0 | c[7:0]);
            tick(dv[c] - 1);
            rdc(8'h30, 8'h00);
            tick(1);
            rdc(8'h30, 8'h01);
            wr(8'h30, 8'h01);
        end
    endtask : t_prescale
    task t_auto;
        wr(8'h25, 8'h01);
        wr(8'h23, 8'hfc);
        tick(2);
        rdc(8'h23, 8'hbc);
        rdc(8'h27, 8'h01);
        check("trim", 1, n_trim);
        check("card", 1, n_card);
        check("field", 1, CARD_FIELD_TIMER_SEL);
        TRIM_DONE <= 1'b1;
        @(posedge CLOCK);
        TRIM_DONE <= 1'b0;
        repeat (2) @(posedge CLOCK);
        check("pd", 0, n_pd);
        card_done(1'b0);
        check("pd", 1, n_pd);
        wr(8'h23, 8'h1c);
        tick(2);
        card_done(1'b1);
        rdc(8'h30, 8'h03);
        check("pd", 1, n_pd);
        wr(8'h30, 8'h03);
        wr(8'h23, 8'h18);
        tick(2);
        card_done(1'b0);
        rdc(8'h23, 8'h98);
        check("pd", 1, n_pd);
        check("card", 3, n_card);
    endtask : t_auto
    task t_reset;
        RST_B <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        rdc(8'h23, 8'h00);
        rdc(8'h27, 8'h00);
        rdc(8'h24, 8'h00);
        check("irq", 0, IRQ);
    endtask : t_reset
    // ==========================================
    // Main sequence
    initial begin
        {errors, num_checks, n_trim, n_card, n_wake, n_pd} = '0;
        {RST_B, AVS_READ, AVS_WRITE, LOW_FREQ_OSC_TICK, TRIM_DONE} = '0;
        {CARD_DETECT_DONE, CARD_FOUND, AVS_ADDRESS, AVS_WRITEDATA} = '0;
        repeat (12) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        t_regs();
        t_run();
        t_underflow();
        t_prescale();
        t_auto();
        t_reset();
        results();
    end
endmodule : test_wtl_top
bind wtl_top wtl_top_checker #(.COUNT_WIDTH(COUNT_WIDTH)) wtl_top_checker_inst (
    .CLOCK(CLOCK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .LOW_FREQ_OSC_TICK(LOW_FREQ_OSC_TICK), .TRIM_START(TRIM_START), .TRIM_DONE(TRIM_DONE),
    .CARD_DETECT_START(CARD_DETECT_START), .CARD_FIELD_TIMER_SEL(CARD_FIELD_TIMER_SEL),
    .CARD_DETECT_DONE(CARD_DETECT_DONE), .CARD_FOUND(CARD_FOUND), .WAKE_REQ(WAKE_REQ),
    .POWER_DOWN_REQ(POWER_DOWN_REQ), .IRQ(IRQ));
